// [acc_control.v]
/*
  converter calibration control: power-on and on-command calibration
  sequencing, out-of-range flag, range select and output edge select.
  assumes pins are asynchronous to core_clk, data_clock_in is a sampled
  input, and a plain single-cycle register port from local software.
*/
`timescale 1ns/1ps
`include "acc_defines.vh"

module acc_control #(
  parameter DLY_SHORT_CYC = (32'h1 << `ACC_DLY_SHORT_LOG2),
  parameter DLY_LONG_CYC  = (32'h1 << `ACC_DLY_LONG_LOG2),
  parameter CAL_CYC       = `ACC_CAL_CYC
) (
  // clock and reset
  input  wire        core_clk,
  input  wire        rst,
  // control pins
  input  wire        calibration_request,
  input  wire        calibration_delay_select,
  input  wire        powerdown_request,
  input  wire        full_scale_select,
  input  wire        output_edge_select,
  input  wire        data_clock_in,
  // conversion results, same domain
  input  wire        bus_a_over,
  input  wire        bus_b_over,
  input  wire [7:0]  bus_a_data,
  input  wire [7:0]  bus_b_data,
  // outputs
  output reg         calibration_active,
  output reg         out_of_range_pos,
  output reg         out_of_range_neg,
  output reg         range_800mv,
  output reg         analog_powerdown,
  output reg  [7:0]  data_out_a,
  output reg  [7:0]  data_out_b,
  output reg         irq,
  // register port
  input  wire [3:0]  reg_addr,
  input  wire [31:0] reg_wdata,
  input  wire        reg_wr,
  input  wire        reg_rd,
  output reg  [31:0] reg_rdata
);

  // ==========================================================
  // pin synchronisers
  reg [1:0] cal_s_q, dly_s_q, pd_s_q, fs_s_q, edge_s_q, data_clock_out_pos_s_q;
  always @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      cal_s_q  <= 2'h0;
      dly_s_q  <= 2'h0;
      pd_s_q   <= 2'h0;
      fs_s_q   <= 2'h0;
      edge_s_q <= 2'h0;
      data_clock_out_pos_s_q <= 2'h0;
    end
    else
    begin
      cal_s_q  <= {cal_s_q[0], calibration_request};
      dly_s_q  <= {dly_s_q[0], calibration_delay_select};
      pd_s_q   <= {pd_s_q[0], powerdown_request};
      fs_s_q   <= {fs_s_q[0], full_scale_select};
      edge_s_q <= {edge_s_q[0], output_edge_select};
      data_clock_out_pos_s_q <= {data_clock_out_pos_s_q[0], data_clock_in};
    end
  end
  wire cal_pin  = cal_s_q[1];
  wire pd_pin   = pd_s_q[1];
  reg  data_clock_out_pos_prev_q;

  // ==========================================================
  // registers
  reg        sw_cal_q;
  reg        force_cal_q;
  reg  [2:0] irq_stat_q;
  reg  [2:0] irq_en_q;
  reg  [2:0] state_q;
  reg  [30:0] cnt_q;
  reg  [3:0] lo_cnt_q, hi_cnt_q;
  reg        armed_q;
  reg  [1:0] started_q;
  reg        cal_pin_init_q;

  wire [2:0] ev;
  wire       req_ok;
  wire [30:0] dly_target = dly_s_q[1] ? DLY_LONG_CYC[30:0] : DLY_SHORT_CYC[30:0];

  // ==========================================================
  // request qualifier
  always @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      lo_cnt_q <= 4'h0;
      hi_cnt_q <= 4'h0;
      armed_q  <= 1'b0;
    end
    else if (state_q == `ACC_ST_PD)
    begin
      lo_cnt_q <= 4'h0;
      hi_cnt_q <= 4'h0;
      armed_q  <= 1'b0;
    end
    else if (!cal_pin)
    begin
      hi_cnt_q <= 4'h0;
      // high phase cut short: low phase must be qualified again
      if (armed_q && hi_cnt_q != 4'h0)
      begin
        armed_q  <= 1'b0;
        lo_cnt_q <= 4'h1;
      end
      else
      begin
        if (lo_cnt_q != `ACC_REQ_LOW_CYC)
          lo_cnt_q <= lo_cnt_q + 4'h1;
        if (lo_cnt_q >= `ACC_REQ_LOW_CYC - 1)
          armed_q <= 1'b1;
      end
    end
    else
    begin
      if (!armed_q)
        lo_cnt_q <= 4'h0;
      if (armed_q && hi_cnt_q != `ACC_REQ_HIGH_CYC)
        hi_cnt_q <= hi_cnt_q + 4'h1;
      if (req_ok)
      begin
        armed_q  <= 1'b0;
        lo_cnt_q <= 4'h0;
        hi_cnt_q <= 4'h0;
      end
    end
  end
  // start 10 cycles after high, after 10 low cycles
  assign req_ok = armed_q && cal_pin && (hi_cnt_q == `ACC_REQ_HIGH_CYC - 1);

  // ==========================================================
  // calibration sequencer
  always @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      state_q            <= `ACC_ST_DELAY;
      cnt_q              <= 31'h0;
      started_q          <= 2'h0;
      cal_pin_init_q     <= 1'b0;
      calibration_active <= 1'b0;
      analog_powerdown   <= 1'b1;
    end
    else
    begin
      // request pin level two sync stages after release is the power-up level
      if (started_q != 2'h3)
        started_q <= started_q + 2'h1;
      if (started_q == 2'h2)
        cal_pin_init_q <= cal_pin;
      case (state_q)
        `ACC_ST_DELAY:
        begin
          analog_powerdown <= pd_pin;
          if (started_q == 2'h3 && cal_pin_init_q)
            state_q <= `ACC_ST_IDLE;
          else if (pd_pin)
            cnt_q <= cnt_q;
          else if (cnt_q >= dly_target - 31'h1)
          begin
            cnt_q              <= 31'h0;
            state_q            <= `ACC_ST_CAL;
            calibration_active <= 1'b1;
          end
          else
            cnt_q <= cnt_q + 31'h1;
        end
        `ACC_ST_IDLE:
        begin
          if (pd_pin)
          begin
            state_q          <= `ACC_ST_PD;
            analog_powerdown <= 1'b1;
          end
          else if (req_ok || sw_cal_q)
          begin
            cnt_q              <= 31'h0;
            state_q            <= `ACC_ST_CAL;
            calibration_active <= 1'b1;
          end
        end
        `ACC_ST_CAL:
        begin
          if (cnt_q == CAL_CYC - 1)
          begin
            cnt_q              <= 31'h0;
            calibration_active <= 1'b0;
            state_q            <= `ACC_ST_IDLE;
          end
          else
            cnt_q <= cnt_q + 31'h1;
        end
        `ACC_ST_PD:
        begin
          if (!pd_pin)
          begin
            state_q          <= `ACC_ST_IDLE;
            analog_powerdown <= 1'b0;
          end
        end
        default:
          state_q <= `ACC_ST_IDLE;
      endcase
    end
  end

  // ==========================================================
  // range, out-of-range and output data
  always @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      out_of_range_pos <= 1'b0;
      out_of_range_neg <= 1'b1;
      range_800mv      <= 1'b0;
      data_out_a       <= 8'h00;
      data_out_b       <= 8'h00;
      data_clock_out_pos_prev_q      <= 1'b0;
    end
    else
    begin
      out_of_range_pos <= bus_a_over | bus_b_over;
      out_of_range_neg <= ~(bus_a_over | bus_b_over);
      range_800mv      <= fs_s_q[1];
      data_clock_out_pos_prev_q      <= data_clock_out_pos_s_q[1];
      if (edge_s_q[1] ? (data_clock_out_pos_s_q[1] & ~data_clock_out_pos_prev_q) : (~data_clock_out_pos_s_q[1] & data_clock_out_pos_prev_q))
      begin
        data_out_a <= bus_a_data;
        data_out_b <= bus_b_data;
      end
    end
  end

  // ==========================================================
  // interrupts and register port
  assign ev = {bus_a_over | bus_b_over,
               state_q == `ACC_ST_CAL && cnt_q == CAL_CYC - 1,
               state_q == `ACC_ST_CAL && cnt_q == 31'h0};

  always @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      sw_cal_q    <= 1'b0;
      force_cal_q <= 1'b0;
      irq_stat_q  <= 3'h0;
      irq_en_q    <= 3'h0;
      irq         <= 1'b0;
      reg_rdata   <= 32'h0;
    end
    else
    begin
      sw_cal_q <= reg_wr && reg_addr == `ACC_REG_CTRL && reg_wdata[`ACC_CTRL_SW_CAL];
      if (reg_wr && reg_addr == `ACC_REG_CTRL)
        force_cal_q <= reg_wdata[`ACC_CTRL_FORCE_CAL];
      if (reg_wr && reg_addr == `ACC_REG_IRQ_EN)
        irq_en_q <= reg_wdata[2:0];
      if (reg_wr && reg_addr == `ACC_REG_IRQ_CLR)
        irq_stat_q <= (irq_stat_q & ~reg_wdata[2:0]) | ev;
      else
        irq_stat_q <= irq_stat_q | ev;
      irq <= |(irq_stat_q & irq_en_q);
      reg_rdata <= 32'h0;
      if (reg_rd)
      begin
        case (reg_addr)
          `ACC_REG_CTRL:     reg_rdata <= {30'h0, force_cal_q, 1'b0};
          `ACC_REG_STATUS:   reg_rdata <= {24'h0, analog_powerdown, out_of_range_pos,
                                           range_800mv, edge_s_q[1], state_q,
                                           calibration_active};
          `ACC_REG_IRQ_STAT: reg_rdata <= {29'h0, irq_stat_q};
          `ACC_REG_IRQ_EN:   reg_rdata <= {29'h0, irq_en_q};
          default:           reg_rdata <= 32'h0;
        endcase
      end
    end
  end

endmodule // acc_control

// [acc_defines.vh]
/*
  constants for the converter calibration control block.
  assumes inclusion by bare name from the design file.
*/
`ifndef ACC_DEFINES_VH
`define ACC_DEFINES_VH
// request qualification
`define ACC_REQ_LOW_CYC    10
`define ACC_REQ_HIGH_CYC   10
// power-on delay exponents
`define ACC_DLY_SHORT_LOG2 24
`define ACC_DLY_LONG_LOG2  30
// calibration sequence length in core cycles
`define ACC_CAL_CYC        1024
// register offsets
`define ACC_REG_CTRL       4'h0
`define ACC_REG_STATUS     4'h1
`define ACC_REG_IRQ_STAT   4'h2
`define ACC_REG_IRQ_EN     4'h3
`define ACC_REG_IRQ_CLR    4'h4
// ctrl field positions
`define ACC_CTRL_SW_CAL    0
`define ACC_CTRL_FORCE_CAL 1
// irq bits
`define ACC_IRQ_CAL_START  0
`define ACC_IRQ_CAL_DONE   1
`define ACC_IRQ_OOR        2
`define ACC_IRQ_W          3
// state codes
`define ACC_ST_DELAY       3'h0
`define ACC_ST_IDLE        3'h1
`define ACC_ST_START       3'h2
`define ACC_ST_CAL         3'h3
`define ACC_ST_PD          3'h4
`endif

// [acc_control_chk.sv]
/*
  pin-level checker for acc_control.
  assumes bind onto acc_control, one core_clk domain, small CAL_CYC in sim.
*/
`timescale 1ns/1ps
module acc_chk #(
  parameter CAL_CYC = 16
) (
  // clock and reset
  input wire        core_clk,
  input wire        rst,
  // pins seen
  input wire        full_scale_select,
  input wire        output_edge_select,
  input wire        data_clock_in,
  input wire        bus_a_over,
  input wire        bus_b_over,
  input wire        reg_rd,
  // outputs seen
  input wire        calibration_active,
  input wire        out_of_range_pos,
  input wire        out_of_range_neg,
  input wire        range_800mv,
  input wire        analog_powerdown,
  input wire [7:0]  data_out_a,
  input wire [31:0] reg_rdata
);
  // ==========
  // helpers
  reg  [15:0] act_n;
  reg  [5:0]  dck_h;
  wire        rise_w = |(dck_h[4:0] & ~dck_h[5:1]);
  wire        fall_w = |(~dck_h[4:0] & dck_h[5:1]);
  always @(posedge core_clk or posedge rst)
    if (rst)
      act_n <= 16'h0;
    else
      act_n <= calibration_active ? act_n + 16'h1 : 16'h0;
  always @(posedge core_clk)
    dck_h <= {dck_h[4:0], data_clock_in};
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (rst);
  sequence s_cal_start;
    $rose(calibration_active);
  endsequence
  sequence s_cal_end;
    $fell(calibration_active);
  endsequence
  // ==========
  // properties
  a_oor_set: assert property (
    (bus_a_over || bus_b_over) |=> out_of_range_pos && !out_of_range_neg)
    else $error("range flag not raised");
  a_oor_clear: assert property (
    !(bus_a_over || bus_b_over) |=> !out_of_range_pos && out_of_range_neg)
    else $error("range flag not cleared");
  a_range_follow: assert property (
    $stable(full_scale_select) [*5] |-> range_800mv == full_scale_select)
    else $error("range select not followed");
  a_cal_length: assert property (
    s_cal_end |-> act_n == CAL_CYC)
    else $error("calibration length wrong");
  a_cal_pd_apart: assert property (
    !(analog_powerdown && calibration_active))
    else $error("power down during calibration");
  a_start_awake: assert property (
    s_cal_start |-> !$past(analog_powerdown, 2))
    else $error("calibration started in power down");
  a_data_edge: assert property (
    $changed(data_out_a) |-> (output_edge_select ? rise_w : fall_w))
    else $error("data moved on wrong edge");
  a_rdata_idle: assert property (
    !reg_rd |=> reg_rdata == 32'h0)
    else $error("read data not idle");
  c_cal: cover property (s_cal_start);
endmodule // acc_chk

bind acc_control acc_chk #(.CAL_CYC(CAL_CYC)) chk_u (.core_clk, .rst, .full_scale_select,
  .output_edge_select, .data_clock_in, .bus_a_over, .bus_b_over, .reg_rd, .calibration_active,
  .out_of_range_pos, .out_of_range_neg, .range_800mv, .analog_powerdown, .data_out_a,
  .reg_rdata);

// [acc_rx_model.sv]
/*
  receiving logic model: makes the free-running data clock, latches bus a.
  assumes data_out_a moves shortly after the selected launch edge.
*/
`timescale 1ns/1ps
module acc_rx_model (
  // data clock and select
  output reg        data_clock_in,
  input  wire       output_edge_select,
  // data and capture
  input  wire [7:0] data_out_a,
  output reg  [7:0] cap_a,
  output reg        skew_q
);
  realtime t_edge;
  initial
  begin
    data_clock_in = 1'b0;
    cap_a = 8'h0;
    skew_q = 1'b0;
    t_edge = 0.0;
    #3;
    forever #62.5 data_clock_in = ~data_clock_in;
  end
  // note launch edge, capture on the other one
  always @(posedge data_clock_in)
    if (output_edge_select)
      t_edge = $realtime;
    else
      cap_a <= data_out_a;
  always @(negedge data_clock_in)
    if (!output_edge_select)
      t_edge = $realtime;
    else
      cap_a <= data_out_a;
  // data far from launch edge is flagged
  always @(data_out_a)
    if ($realtime - t_edge > 55.0)
      skew_q = 1'b1;
endmodule // acc_rx_model

// [test_acc_control.sv]
/*
  testbench for acc_control: pins, register port, receiving model.
  assumes acc_defines.vh on the include path.
*/
`timescale 1ns/1ps
`include "acc_defines.vh"
module test_acc_control;
  reg        core_clk = 1'b0, rst = 1'b1, calibration_request = 1'b0;
  reg        calibration_delay_select = 1'b0, powerdown_request = 1'b0, full_scale_select = 1'b0;
  reg        output_edge_select = 1'b1, bus_a_over = 1'b0, bus_b_over = 1'b0;
  reg        reg_wr = 1'b0, reg_rd = 1'b0;
  reg [7:0]  bus_a_data = 8'h0, bus_b_data = 8'h0;
  reg [3:0]  reg_addr = 4'h0;
  reg [31:0] reg_wdata = 32'h0, rd_v;
  wire       calibration_active, out_of_range_pos, out_of_range_neg, range_800mv;
  wire       analog_powerdown, irq, data_clock_in, skew_q;
  wire [7:0] data_out_a, data_out_b, cap_a;
  wire [31:0] reg_rdata;
  integer    bad_count = 0, n_checks = 0, n, i;
  always #5 core_clk = ~core_clk;
  acc_control #(.DLY_SHORT_CYC(64), .DLY_LONG_CYC(128), .CAL_CYC(16)) dut_u (.core_clk, .rst,
    .calibration_request, .calibration_delay_select, .powerdown_request, .full_scale_select,
    .output_edge_select, .data_clock_in, .bus_a_over, .bus_b_over, .bus_a_data, .bus_b_data,
    .calibration_active, .out_of_range_pos, .out_of_range_neg, .range_800mv, .analog_powerdown,
    .data_out_a, .data_out_b, .irq, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata);
  acc_rx_model rx_u (.data_clock_in, .output_edge_select, .data_out_a, .cap_a, .skew_q);
  // ==========
  // tasks
  task finish_test;
    begin
      $display("checks %0d errors %0d", n_checks, bad_count);
      if (bad_count == 0 && n_checks > 0)
        $display("[ PASS ]");
      else
        $display("[ FAIL ]");
      $finish;
    end
  endtask
  task chk(input [31:0] seen, input [31:0] exp);
    begin
      n_checks = n_checks + 1;
      if (seen !== exp)
      begin
        bad_count = bad_count + 1;
        $display("[ERR] %0t seen %h exp %h", $time, seen, exp);
      end
    end
  endtask
  task cyc(input integer k);
    begin
      repeat (k) @(posedge core_clk);
      #1;
    end
  endtask
  task wr(input [3:0] a, input [31:0] d);
    begin
      @(posedge core_clk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge core_clk);
      reg_wr <= 1'b0;
    end
  endtask
  task rd(input [3:0] a);
    begin
      @(posedge core_clk);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge core_clk);
      reg_rd <= 1'b0;
      #1;
      rd_v = reg_rdata;
    end
  endtask
  task wait_act(input v, input integer lim, input must);
    begin
      n = 0;
      while (calibration_active !== v && n < lim)
      begin
        cyc(1);
        n = n + 1;
      end
      if (must && n >= lim)
      begin
        bad_count = bad_count + 1;
        finish_test;
      end
    end
  endtask
  task req(input integer lo, input integer hi);
    begin
      calibration_request <= 1'b0;
      cyc(lo);
      calibration_request <= 1'b1;
      cyc(hi);
    end
  endtask
  task do_reset;
    begin
      rst <= 1'b1;
      cyc(2);
      rst <= 1'b0;
    end
  endtask
  // ==========
  // sequence
  initial
  begin
    do_reset;
    wait_act(1, 200, 1);
    chk(n >= 62, 1);
    wait_act(0, 40, 1);
    chk(n, 16);
    rd(`ACC_REG_IRQ_STAT);
    chk(rd_v, 32'h3);
    wr(`ACC_REG_IRQ_EN, 32'h2);
    rd(`ACC_REG_IRQ_EN);
    chk(rd_v, 32'h2);
    rd(4'hf);
    chk(rd_v, 32'h0);
    chk(irq, 1);
    wr(`ACC_REG_IRQ_CLR, 32'h7);
    cyc(2);
    chk(irq, 0);
    wr(`ACC_REG_CTRL, 32'h1);
    powerdown_request <= 1'b1;
    wait_act(1, 10, 1);
    chk(analog_powerdown, 0);
    wait_act(0, 40, 1);
    cyc(6);
    chk({analog_powerdown, irq}, 2'h3);
    req(12, 12);
    wait_act(1, 30, 0);
    chk(n, 30);
    powerdown_request <= 1'b0;
    req(9, 12);
    wait_act(1, 30, 0);
    chk(n, 30);
    req(12, 8);
    calibration_request <= 1'b0;
    wait_act(1, 30, 0);
    chk(n, 30);
    req(0, 0);
    wait_act(1, 30, 1);
    chk(n >= 10 && n <= 15, 1);
    wait_act(0, 40, 1);
    for (i = 0; i < 3; i = i + 1)
    begin
      bus_a_over <= (i == 0);
      bus_b_over <= (i == 1);
      full_scale_select <= (i != 1);
      cyc(6);
      chk({out_of_range_pos, out_of_range_neg, range_800mv}, {i != 2, i == 2, i != 1});
    end
    calibration_request <= 1'b1;
    do_reset;
    wait_act(1, 150, 0);
    chk(n, 150);
    req(12, 0);
    wait_act(1, 30, 1);
    wait_act(0, 40, 1);
    calibration_request <= 1'b0;
    powerdown_request <= 1'b1;
    calibration_delay_select <= 1'b1;
    do_reset;
    wait_act(1, 200, 0);
    chk(n, 200);
    chk(analog_powerdown, 1);
    powerdown_request <= 1'b0;
    wait_act(1, 300, 1);
    chk(n >= 126, 1);
    for (i = 1; i >= 0; i = i - 1)
    begin
      output_edge_select <= i[0];
      cyc(20);
      bus_a_data <= 8'h5a ^ {8{i[0]}};
      bus_b_data <= 8'h3c ^ {8{i[0]}};
      cyc(40);
      chk({skew_q, cap_a}, {1'b0, 8'h5a ^ {8{i[0]}}});
      chk(data_out_b, 8'h3c ^ {8{i[0]}});
    end
    finish_test;
  end
endmodule // test_acc_control
